// ==== rtl/ncd_consts.svh ====
/*
 Constants of the nibble core data path: entry addresses, memory sizes,
 pointer and stack geometry, decimal-adjust figures.
 Assumes inclusion by bare name from the package and the design modules.
*/
// How it works
// - PC loads 000H on reset and fixed vectors 010H..028H per interrupt.
// - Table ROM sits above the instruction area in the shared ROM.
// - Table reads return a byte or a nibble; nibble space is twice as deep.
// - The index pointer supplies every table ROM read address.
// - Index pointer is 12 bits, changed only by the two pointer loads.
// - Lower pointer load copies the addressed RAM nibble into bits 3..0.
// - Upper pointer load writes bits 11..4 from RAM nibble and accumulator.
// - Indirect accesses reach whole table ROM for N of 8 and up, and RAM 00H..7FH.
// - Return stack holds eight 11-bit entries, no overflow or underflow flag.
// - Call or interrupt pushes PC; return pops the latest entry, LIFO.
// - Push when full wraps pointer to level 0 and overwrites that entry.
// - Pop when empty wraps pointer to level 7 and loads PC from it.
// - Data memory is 128 locations of 4 bits.
// - Direct addressing takes the RAM address 00H..7FH from the instruction.
// - RAM 70H..7FH double as sixteen working registers.
// - ALU ops between working register and immediate; moves WR to/from RAM.
// - ALU: add, sub, inc, dec with carry, logic, shifts, branch tests, BCD.
// - Adjust after add: 0-9,C0 keep; A-F,C0 add 6 set C; 0-3,C1 add 6.
// - Adjust after sub: 0-9,C1 keep; 6-F,C0 add A mod 16; carry kept.
// - Instruction area is 128*N words; table ROM 256*(16-N) bytes.
// - Program counter is 11 bits over a 2048-word range.
`ifndef NCD_CONSTS_SVH
`define NCD_CONSTS_SVH
`define NCD_PC_W 11
`define NCD_PTR_W 12
`define NCD_ROM_DEPTH 2048
`define NCD_RAM_DEPTH 128
`define NCD_STK_DEPTH 8
`define NCD_VEC_RESET 11'h000
`define NCD_VEC_INT2 11'h010
`define NCD_VEC_INT0 11'h014
`define NCD_VEC_INT1 11'h018
`define NCD_VEC_INT3 11'h01C
`define NCD_VEC_INT4 11'h020
`define NCD_VEC_INT5 11'h024
`define NCD_VEC_INT6 11'h028
`define NCD_PAGE_WORDS 12'h080
`define NCD_TABLE_ROM_PAGE_BYTES 12'h100
`define NCD_WR_BASE 7'h70
`define NCD_BCD_ADD_FIX 4'h6
`define NCD_BCD_SUB_FIX 4'hA
`define NCD_STK_TOP 3'h7
`define NCD_PART_N_DEF 5'h08
`endif

// ==== rtl/ncd_pkg.sv ====
/*
 Types of the nibble core data path: ALU operations and PC sources.
 Assumes the constants header is on the include path.
*/
`include "ncd_consts.svh"
package ncd_pkg;
    typedef enum logic [4:0] {
        NCD_OP_NONE = 5'h00,
        NCD_OP_ADC = 5'h01,
        NCD_OP_ADD = 5'h02,
        NCD_OP_SBC = 5'h03,
        NCD_OP_SUB = 5'h04,
        NCD_OP_ADN = 5'h05,
        NCD_OP_INC = 5'h06,
        NCD_OP_DEC = 5'h07,
        NCD_OP_AND = 5'h08,
        NCD_OP_EOR = 5'h09,
        NCD_OP_OR = 5'h0A,
        NCD_OP_SR0 = 5'h0B,
        NCD_OP_SR1 = 5'h0C,
        NCD_OP_SL0 = 5'h0D,
        NCD_OP_SL1 = 5'h0E,
        NCD_OP_DAA = 5'h0F,
        NCD_OP_DAS = 5'h10,
        NCD_OP_PASS = 5'h11
    } ncd_alu_op_t;
    typedef enum logic [2:0] {
        NCD_PC_INC = 3'h0,
        NCD_PC_JUMP = 3'h1,
        NCD_PC_CALL = 3'h2,
        NCD_PC_INT = 3'h3,
        NCD_PC_RET = 3'h4,
        NCD_PC_HOLD = 3'h5
    } ncd_pc_src_t;
    typedef enum logic [2:0] {
        NCD_BR_B0 = 3'h0,
        NCD_BR_B1 = 3'h1,
        NCD_BR_B2 = 3'h2,
        NCD_BR_B3 = 3'h3,
        NCD_BR_C = 3'h4,
        NCD_BR_NC = 3'h5,
        NCD_BR_Z = 3'h6,
        NCD_BR_NZ = 3'h7
    } ncd_br_t;
endpackage

// ==== rtl/ncd_alu.sv ====
/*
 Combinational 4-bit ALU with binary, logic, shift and decimal-adjust ops.
 Assumes operands and carry come from registers of the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ncd_consts.svh"
module ncd_alu
    import ncd_pkg::*;
(
    input wire ncd_alu_op_t op_in,
    input wire logic [3:0] a_in,
    input wire logic [3:0] b_in,
    input wire logic carry_in,
    output logic [3:0] res_out,
    output logic carry_out
);
    logic [4:0] sum;

    always_comb
    begin
        sum = 5'h00;
        res_out = a_in;
        carry_out = carry_in;
        case (op_in)
            // Binary arithmetic with carry as borrow-free flag
            NCD_OP_ADC:
            begin
                sum = {1'b0, a_in} + {1'b0, b_in} + {4'h0, carry_in};
                res_out = sum[3:0];
                carry_out = sum[4];
            end
            NCD_OP_ADD:
            begin
                sum = {1'b0, a_in} + {1'b0, b_in};
                res_out = sum[3:0];
                carry_out = sum[4];
            end
            NCD_OP_ADN:
            begin
                sum = {1'b0, a_in} + {1'b0, b_in};
                res_out = sum[3:0];
            end
            NCD_OP_SBC:
            begin
                sum = {1'b0, b_in} + {1'b0, ~a_in} + {4'h0, carry_in};
                res_out = sum[3:0];
                carry_out = sum[4];
            end
            NCD_OP_SUB:
            begin
                sum = {1'b0, b_in} + {1'b0, ~a_in} + 5'h01;
                res_out = sum[3:0];
                carry_out = sum[4];
            end
            NCD_OP_INC:
            begin
                sum = {1'b0, b_in} + 5'h01;
                res_out = sum[3:0];
                carry_out = sum[4];
            end
            NCD_OP_DEC:
            begin
                sum = {1'b0, b_in} + 5'h1F;
                res_out = sum[3:0];
                carry_out = sum[4];
            end
            NCD_OP_AND: res_out = a_in & b_in;
            NCD_OP_EOR: res_out = a_in ^ b_in;
            NCD_OP_OR: res_out = a_in | b_in;
            NCD_OP_SR0: res_out = {1'b0, b_in[3:1]};
            NCD_OP_SR1: res_out = {1'b1, b_in[3:1]};
            NCD_OP_SL0: res_out = {b_in[2:0], 1'b0};
            NCD_OP_SL1: res_out = {b_in[2:0], 1'b1};
            NCD_OP_DAA:
            begin
                // Combinations outside the table are left unchanged
                if (!carry_in && b_in >= 4'hA)
                begin
                    res_out = b_in + `NCD_BCD_ADD_FIX;
                    carry_out = 1'b1;
                end
                else if (carry_in && b_in <= 4'h3)
                    res_out = b_in + `NCD_BCD_ADD_FIX;
                else
                    res_out = b_in;
            end
            NCD_OP_DAS:
            begin
                // Carry is never touched here
                if (!carry_in && b_in >= 4'h6)
                    res_out = b_in + `NCD_BCD_SUB_FIX;
                else
                    res_out = b_in;
            end
            NCD_OP_PASS: res_out = b_in;
            default: res_out = a_in;
        endcase
    end
endmodule
`default_nettype wire

// ==== rtl/ncd_stack.sv ====
/*
 Eight-level return-address stack with wrap on overflow and underflow.
 Assumes push and pop are never asserted in the same cycle.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ncd_consts.svh"
module ncd_stack
    import ncd_pkg::*;
(
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic [`NCD_PC_W-1:0] push_data_in,
    output logic [`NCD_PC_W-1:0] top_out,
    output logic [2:0] level_out
);
    logic [`NCD_PC_W-1:0] mem_q [`NCD_STK_DEPTH];
    logic [2:0] sp_q;
    logic [2:0] sp_d;

    // Pointer names the next free slot; pop reads the slot below it
    always_comb
    begin
        sp_d = sp_q;
        if (push_in)
            sp_d = sp_q + 3'h1;
        else if (pop_in)
            sp_d = sp_q - 3'h1;
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
            sp_q <= 3'h0;
        else
            sp_q <= sp_d;
        if (push_in)
            mem_q[sp_q] <= push_data_in;
    end

    // No flag: a ninth push silently overwrites level 0
    assign top_out = mem_q[sp_q - 3'h1];
    assign level_out = sp_q;

    stack_wrap_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        pop_in && !push_in && sp_q == 3'h0 |=> sp_q == `NCD_STK_TOP)
        else $error("stack pointer did not wrap to level 7");
    stack_lifo_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        push_in && !pop_in ##1 pop_in && !push_in |-> top_out == $past(push_data_in))
        else $error("pop did not return last pushed value");
endmodule
`default_nettype wire

// ==== rtl/ncd_datapath.sv ====
/*
 Data path of a 4-bit core: program counter, shared instruction/table ROM,
 index pointer, return stack, 128 x 4 data RAM, accumulator, carry and ALU.
 Assumes an instruction decoder on the same clock drives the control ports
 one instruction per cycle; ROM contents are loaded by the mask port.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ncd_consts.svh"
module ncd_datapath
    import ncd_pkg::*;
#(
    parameter logic [4:0] PART_N = `NCD_PART_N_DEF
)
(
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire ncd_pc_src_t pc_src_in,
    input wire logic [`NCD_PC_W-1:0] jump_addr_in,
    input wire logic [2:0] int_num_in,
    input wire logic branch_in,
    input wire ncd_br_t branch_cond_in,
    input wire ncd_alu_op_t alu_op_in,
    input wire logic use_imm_in,
    input wire logic [3:0] imm_in,
    input wire logic [6:0] direct_addr_in,
    input wire logic [3:0] wr_sel_in,
    input wire logic use_wr_in,
    input wire logic indirect_in,
    input wire logic ram_we_in,
    input wire logic ram_src_wr_in,
    input wire logic acc_we_in,
    input wire logic carry_we_in,
    input wire logic load_pointer_lower_in,
    input wire logic load_pointer_upper_in,
    input wire logic table_rd_in,
    input wire logic table_nibble_in,
    input wire logic rom_we_in,
    input wire logic [`NCD_PC_W-1:0] rom_waddr_in,
    input wire logic [15:0] rom_wdata_in,
    output logic [`NCD_PC_W-1:0] pc_out,
    output logic [15:0] instr_out,
    output logic [3:0] accumulator_out,
    output logic carry_flag_out,
    output logic zero_out,
    output logic [`NCD_PTR_W-1:0] index_pointer_out,
    output logic [7:0] table_data_out,
    output logic table_err_out,
    output logic [3:0] ram_rdata_out,
    output logic [2:0] stack_level_out
);
    logic [15:0] rom_q [`NCD_ROM_DEPTH];
    logic [3:0] ram_q [`NCD_RAM_DEPTH];
    logic [`NCD_PC_W-1:0] pc_q, pc_d;
    logic [`NCD_PTR_W-1:0] index_pointer_q, index_pointer_d;
    logic [3:0] accumulator_q, accumulator_d;
    logic carry_flag_q, carry_flag_d;
    logic [15:0] instr_q;
    logic [7:0] table_data_q, table_data_d;
    logic table_err_q, table_err_d;
    logic [`NCD_PC_W-1:0] stk_top;
    logic [6:0] ram_addr;
    logic [3:0] ram_rd;
    logic [3:0] wr_rd;
    logic [3:0] alu_a, alu_res;
    logic alu_carry;
    logic br_taken;
    logic [`NCD_PC_W-1:0] tbyte_idx;
    logic [15:0] tword;
    logic [11:0] instruction_rom_words;

    function automatic logic [`NCD_PC_W-1:0] vec_of(input logic [2:0] n);
        case (n)
            3'h0: vec_of = `NCD_VEC_INT0;
            3'h1: vec_of = `NCD_VEC_INT1;
            3'h2: vec_of = `NCD_VEC_INT2;
            3'h3: vec_of = `NCD_VEC_INT3;
            3'h4: vec_of = `NCD_VEC_INT4;
            3'h5: vec_of = `NCD_VEC_INT5;
            3'h6: vec_of = `NCD_VEC_INT6;
            default: vec_of = `NCD_VEC_RESET;
        endcase
    endfunction

    // Working registers live in the top sixteen RAM cells
    function automatic logic [6:0] wr_addr(input logic [3:0] sel);
        wr_addr = `NCD_WR_BASE | {3'h0, sel};
    endfunction

    // Instruction words fill 128*N, the rest is table bytes
    assign instruction_rom_words = 12'(PART_N) * `NCD_PAGE_WORDS;

    ncd_stack u_stack (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .push_in(pc_src_in == NCD_PC_CALL || pc_src_in == NCD_PC_INT),
        .pop_in(pc_src_in == NCD_PC_RET),
        .push_data_in(pc_q),
        .top_out(stk_top),
        .level_out(stack_level_out)
    );

    // Pointer low 7 bits reach any RAM cell; indirect_in picks pointer vs direct address
    assign ram_addr = indirect_in ? index_pointer_q[6:0] : direct_addr_in;
    assign ram_rd = ram_q[ram_addr];
    assign wr_rd = ram_q[wr_addr(wr_sel_in)];
    assign alu_a = use_imm_in ? imm_in : (use_wr_in ? wr_rd : accumulator_q);

    ncd_alu u_alu (
        .op_in(alu_op_in),
        .a_in(alu_a),
        .b_in(use_wr_in ? wr_rd : ram_rd),
        .carry_in(carry_flag_q),
        .res_out(alu_res),
        .carry_out(alu_carry)
    );

    always_comb
    begin
        case (branch_cond_in)
            NCD_BR_B0: br_taken = accumulator_q[0];
            NCD_BR_B1: br_taken = accumulator_q[1];
            NCD_BR_B2: br_taken = accumulator_q[2];
            NCD_BR_B3: br_taken = accumulator_q[3];
            NCD_BR_C: br_taken = carry_flag_q;
            NCD_BR_NC: br_taken = !carry_flag_q;
            NCD_BR_Z: br_taken = accumulator_q == 4'h0;
            NCD_BR_NZ: br_taken = accumulator_q != 4'h0;
            default: br_taken = 1'b0;
        endcase
    end

    always_comb
    begin
        pc_d = pc_q + 11'h001;
        case (pc_src_in)
            NCD_PC_INC: pc_d = pc_q + 11'h001;
            NCD_PC_JUMP:
            begin
                if (!branch_in || br_taken)
                    pc_d = jump_addr_in;
            end
            NCD_PC_CALL: pc_d = jump_addr_in;
            NCD_PC_INT: pc_d = vec_of(int_num_in);
            NCD_PC_RET: pc_d = stk_top;
            NCD_PC_HOLD: pc_d = pc_q;
            default: pc_d = pc_q + 11'h001;
        endcase
    end

    // Table byte index sits above the instruction area; nibble mode halves it
    always_comb
    begin
        tbyte_idx = table_nibble_in ? index_pointer_q[11:1] : index_pointer_q[10:0];
        tword = rom_q[instruction_rom_words[10:0] + {1'b0, tbyte_idx[10:1]}];
        table_data_d = table_data_q;
        table_err_d = table_err_q;
        if (table_rd_in)
        begin
            // Full 12-bit instruction area size so N=16 (no table space) still flags every read
            table_err_d = (instruction_rom_words + {2'b00, tbyte_idx[10:1]}) >= 12'(`NCD_ROM_DEPTH)
                || (!table_nibble_in && index_pointer_q[11]);
            if (!table_nibble_in)
                table_data_d = tbyte_idx[0] ? tword[15:8] : tword[7:0];
            else if (index_pointer_q[0])
                table_data_d = {4'h0, tbyte_idx[0] ? tword[15:12] : tword[7:4]};
            else
                table_data_d = {4'h0, tbyte_idx[0] ? tword[11:8] : tword[3:0]};
        end
    end

    always_comb
    begin
        index_pointer_d = index_pointer_q;
        if (load_pointer_lower_in)
            index_pointer_d[3:0] = ram_rd;
        else if (load_pointer_upper_in)
            index_pointer_d[11:4] = {accumulator_q, ram_rd};
        accumulator_d = acc_we_in ? alu_res : accumulator_q;
        carry_flag_d = carry_we_in ? alu_carry : carry_flag_q;
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            pc_q <= `NCD_VEC_RESET;
            index_pointer_q <= 12'h000;
            accumulator_q <= 4'h0;
            carry_flag_q <= 1'b0;
            table_data_q <= 8'h00;
            table_err_q <= 1'b0;
            instr_q <= 16'h0000;
        end
        else
        begin
            pc_q <= pc_d;
            index_pointer_q <= index_pointer_d;
            accumulator_q <= accumulator_d;
            carry_flag_q <= carry_flag_d;
            table_data_q <= table_data_d;
            table_err_q <= table_err_d;
            instr_q <= rom_q[pc_q];
        end
        if (rom_we_in)
            rom_q[rom_waddr_in] <= rom_wdata_in;
        // RAM is static: no reset, so contents survive a core reset
        if (ram_we_in)
            ram_q[ram_src_wr_in ? wr_addr(wr_sel_in) : ram_addr] <= ram_src_wr_in ? ram_rd : alu_res;
    end

    assign pc_out = pc_q;
    assign instr_out = instr_q;
    assign accumulator_out = accumulator_q;
    assign carry_flag_out = carry_flag_q;
    assign zero_out = accumulator_q == 4'h0;
    assign index_pointer_out = index_pointer_q;
    assign table_data_out = table_data_q;
    assign table_err_out = table_err_q;
    assign ram_rdata_out = ram_rd;

    reset_vector_a: assert property (@(posedge mclk_in)
        sys_rst_in |=> pc_q == `NCD_VEC_RESET)
        else $error("pc not at reset address");
    int_vector_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        pc_src_in == NCD_PC_INT && int_num_in == 3'h2 |=> pc_q == `NCD_VEC_INT2)
        else $error("interrupt 2 vector wrong");
    ptr_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !load_pointer_lower_in && !load_pointer_upper_in |=> $stable(index_pointer_q))
        else $error("pointer changed without load");
    ptr_low_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        load_pointer_lower_in |=> index_pointer_q[3:0] == $past(ram_rd)
            && index_pointer_q[11:4] == $past(index_pointer_q[11:4]))
        else $error("lower pointer load wrong");
    ptr_high_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        load_pointer_upper_in && !load_pointer_lower_in
            |=> index_pointer_q[11:4] == {$past(accumulator_q), $past(ram_rd)})
        else $error("upper pointer load wrong");
    daa_high_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        alu_op_in == NCD_OP_DAA && acc_we_in && carry_we_in && !use_wr_in && ram_rd >= 4'hA && !carry_flag_q
            |=> carry_flag_q && accumulator_q == $past(ram_rd) + 4'h6)
        else $error("decimal adjust after add wrong");
    das_carry_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        alu_op_in == NCD_OP_DAS && carry_we_in |=> carry_flag_q == $past(carry_flag_q))
        else $error("decimal adjust after sub changed carry");
    push_wrap_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        pc_src_in == NCD_PC_CALL && stack_level_out == `NCD_STK_TOP |=> stack_level_out == 3'h0)
        else $error("stack did not wrap to level 0");
endmodule
`default_nettype wire

// ==== dv/ncd_seq_model.sv ====
/*
 Sequencer model: drives the program counter controls of the data path.
 Assumes one caller process and a free-running clock on mclk_in.
*/
`timescale 1ns/100ps
`default_nettype none
module ncd_seq_model
    import ncd_pkg::*;
(
    input wire logic mclk_in,
    output var ncd_pc_src_t pc_src_out,
    output var logic [10:0] jump_addr_out,
    output var logic [2:0] int_num_out
);
    initial
    begin
        pc_src_out = NCD_PC_HOLD;
        jump_addr_out = 11'h000;
        int_num_out = 3'h0;
    end
    // One request per step, then hold so the PC stays put between steps
    task automatic step(input ncd_pc_src_t src, input logic [10:0] addr, input logic [2:0] num);
        @(posedge mclk_in);
        {pc_src_out, jump_addr_out, int_num_out} <= {src, addr, num};
        @(posedge mclk_in);
        // Stale operands are inverted so a late sample cannot pass by luck
        {pc_src_out, jump_addr_out, int_num_out} <= {NCD_PC_HOLD, ~addr, ~num};
        #1;
    endtask
endmodule
`default_nettype wire

// ==== dv/tb_nibble_core_datapath.sv ====
/*
 Self-checking bench for the nibble core data path with a sequencer model.
 Assumes the design samples all controls on each rising edge of mclk_in.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_nibble_core_datapath
    import ncd_pkg::*;
;
    localparam logic [10:0] F_IMM = 11'h400, F_WR = 11'h200, F_RWE = 11'h100, F_SRC = 11'h080;
    localparam logic [10:0] F_ACC = 11'h040, F_CY = 11'h020, F_LDL = 11'h010, F_LDU = 11'h008;
    localparam logic [10:0] F_TRD = 11'h004, F_NIB = 11'h002, F_IND = 11'h001;
    logic mclk_in, sys_rst_in, rom_we, cy, zero, terr, c, decimal_adjust_sub, br;
    logic [15:0] instr;
    ncd_br_t brc;
    ncd_pc_src_t pc_src;
    ncd_alu_op_t alu_op;
    logic [10:0] jump_addr, pc, j, prev, rom_waddr, ctl;
    logic [10:0] stk [8];
    logic [10:0] vec_tab [8] = '{11'h014, 11'h018, 11'h010, 11'h01C, 11'h020, 11'h024, 11'h028, 11'h000};
    logic [2:0] int_num, lvl, sp;
    logic [3:0] imm, wr_sel, acc, rdata, v, x, k4;
    logic [6:0] direct_addr;
    logic [11:0] p, ptr;
    logic [15:0] rom_wdata, d;
    logic [7:0] tdata, nb;
    int mismatches, n_compared, seed;
    ncd_seq_model seq (.mclk_in(mclk_in), .pc_src_out(pc_src), .jump_addr_out(jump_addr), .int_num_out(int_num));
    ncd_datapath #(.PART_N(5'h08)) DUT (
        .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .pc_src_in(pc_src), .jump_addr_in(jump_addr),
        .int_num_in(int_num), .branch_in(br), .branch_cond_in(brc), .alu_op_in(alu_op),
        .use_imm_in(ctl[10]), .imm_in(imm), .direct_addr_in(direct_addr), .wr_sel_in(wr_sel),
        .use_wr_in(ctl[9]), .indirect_in(ctl[0]), .ram_we_in(ctl[8]), .ram_src_wr_in(ctl[7]),
        .acc_we_in(ctl[6]), .carry_we_in(ctl[5]), .load_pointer_lower_in(ctl[4]),
        .load_pointer_upper_in(ctl[3]), .table_rd_in(ctl[2]), .table_nibble_in(ctl[1]),
        .rom_we_in(rom_we), .rom_waddr_in(rom_waddr), .rom_wdata_in(rom_wdata), .pc_out(pc),
        .instr_out(instr), .accumulator_out(acc), .carry_flag_out(cy), .zero_out(zero),
        .index_pointer_out(ptr), .table_data_out(tdata), .table_err_out(terr), .ram_rdata_out(rdata),
        .stack_level_out(lvl));
    always #5 mclk_in = ~mclk_in;
    task automatic give_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
            mismatches++;
        if (got !== exp)
            $display("Error at %0t: got %h expected %h", $time, got, exp);
    endtask
    // Levels (use_wr, nibble, indirect) stay up after the op so reads can settle
    task automatic op(input ncd_alu_op_t o, input logic [6:0] a, input logic [3:0] w, input logic [3:0] i,
                      input logic [10:0] f);
        @(posedge mclk_in);
        {alu_op, direct_addr, wr_sel, imm, ctl} <= {o, a, w, i, f};
        @(posedge mclk_in);
        ctl <= f & 11'h203;
        alu_op <= NCD_OP_NONE;
        #1;
    endtask
    // RAM has no reset: clear by AND 0 first, then OR in the value
    task automatic wr_ram(input logic [6:0] a, input logic [3:0] val, input logic to_acc);
        op(NCD_OP_AND, a, 4'h0, 4'h0, F_IMM | F_RWE);
        op(NCD_OP_OR, a, 4'h0, val, F_IMM | F_RWE | (to_acc ? F_ACC : 11'h000));
    endtask
    task automatic rom_wr(input logic [10:0] a, input logic [15:0] dw);
        @(posedge mclk_in);
        {rom_we, rom_waddr, rom_wdata} <= {1'b1, a, dw};
        @(posedge mclk_in);
        rom_we <= 1'b0;
    endtask
    function automatic logic [4:0] daa_exp(input logic cf, input logic [3:0] a);
        if ((!cf && a > 4'h9) || (cf && a < 4'h4))
            return {1'b1, a + 4'h6};
        return {cf, a};
    endfunction
    function automatic logic br_exp(input logic [2:0] cc, input logic [3:0] a, input logic cf);
        return (cc < 3'h4) ? a[cc[1:0]] : (cc == 3'h4) ? cf : (cc == 3'h5) ? !cf
            : (cc == 3'h6) ? (a == 4'h0) : (a != 4'h0);
    endfunction
    function automatic logic [4:0] das_exp(input logic cf, input logic [3:0] a);
        if (!cf && a > 4'h5)
            return {1'b0, a + 4'hA};
        return {cf, a};
    endfunction
    initial
    begin
        repeat (60000) @(posedge mclk_in);
        mismatches++;
        give_verdict();
    end
    initial
    begin
        seed = $urandom(32'h13DF);
        {mclk_in, sys_rst_in, rom_we, rom_waddr, rom_wdata, ctl} = {2'b01, 39'h0};
        {direct_addr, wr_sel, imm} = 15'h0000;
        alu_op = NCD_OP_NONE;
        br = 1'b0;
        brc = NCD_BR_Z;
        repeat (16) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        #1;
        chk(pc, 11'h000);
        chk(ptr, 12'h000);
        chk(lvl, 3'h0);
        for (int n = 0; n < 8; n++)
        begin
            seq.step(NCD_PC_INT, 11'h000, 3'(n));
            chk(pc, vec_tab[n]);
            chk(lvl, 3'h1);
            seq.step(NCD_PC_RET, 11'h000, 3'h0);
            chk(pc, 11'h000);
        end
        // Nine pushes then ten pops cover overflow and underflow wrap
        sp = 3'h0;
        for (int i = 0; i < 19; i++)
        begin
            if (i < 9)
            begin
                stk[sp] = pc;
                sp++;
                j = 11'($urandom);
                seq.step(NCD_PC_CALL, j, 3'h0);
                chk(pc, j);
            end
            else
            begin
                sp--;
                seq.step(NCD_PC_RET, 11'h000, 3'h0);
                chk(pc, stk[sp]);
            end
            chk(lvl, sp);
        end
        prev = pc;
        seq.step(NCD_PC_INC, 11'h000, 3'h0);
        chk(pc, 11'(prev + 11'h001));
        for (int i = 0; i < 6; i++)
        begin
            p = (i == 0) ? 12'h801 : 12'($urandom);
            d = 16'($urandom);
            rom_wr(11'h400 + 11'(p[10:1]), d);
            wr_ram(7'h10, p[3:0], 1'b0);
            op(NCD_OP_NONE, 7'h10, 4'h0, 4'h0, F_LDL);
            wr_ram(7'h11, p[7:4], 1'b0);
            wr_ram(7'h12, p[11:8], 1'b1);
            op(NCD_OP_NONE, 7'h11, 4'h0, 4'h0, F_LDU);
            chk(ptr, p);
            op(NCD_OP_NONE, 7'h11, 4'h0, 4'h0, F_TRD);
            chk(terr, p[11]);
            if (!p[11])
                chk(tdata, p[0] ? d[15:8] : d[7:0]);
            d = 16'($urandom);
            rom_wr(11'h400 + 11'(p[11:2]), d);
            op(NCD_OP_NONE, 7'h11, 4'h0, 4'h0, F_TRD | F_NIB);
            nb = p[1] ? d[15:8] : d[7:0];
            chk(tdata[3:0], p[0] ? nb[7:4] : nb[3:0]);
            v = 4'($urandom);
            wr_ram(p[6:0], v, 1'b0);
            op(NCD_OP_NONE, ~p[6:0], 4'h0, 4'h0, F_IND);
            chk(rdata, v);
        end
        for (int k = 0; k < 64; k++)
        begin
            {decimal_adjust_sub, c, v} = 6'(k);
            wr_ram(7'h01, c ? 4'hF : 4'h0, 1'b0);
            op(NCD_OP_ADD, 7'h01, 4'h0, {3'h0, c}, F_IMM | F_CY);
            wr_ram(7'h02, v, 1'b0);
            op(decimal_adjust_sub ? NCD_OP_DAS : NCD_OP_DAA, 7'h02, 4'h0, 4'h0, F_ACC | F_CY);
            chk({cy, acc}, decimal_adjust_sub ? das_exp(c, v) : daa_exp(c, v));
        end
        chk(ptr, p);
        for (int i = 0; i < 4; i++)
        begin
            {k4, v, x} = 12'($urandom);
            wr_ram(7'h70 + 7'(k4), v, 1'b0);
            op(NCD_OP_PASS, 7'h05, k4, 4'h0, F_WR | F_RWE);
            op(NCD_OP_NONE, 7'h05, k4, 4'h0, 11'h000);
            chk(rdata, v);
            op(NCD_OP_ADD, 7'h05, k4, x, F_IMM | F_WR | F_ACC);
            chk(acc, 4'(v + x));
            chk(zero, 4'(v + x) == 4'h0);
            wr_ram(7'h06, 4'(~v), 1'b0);
            op(NCD_OP_NONE, 7'h06, k4, 4'h0, F_RWE | F_SRC);
            op(NCD_OP_NONE, 7'h70 + 7'(k4), k4, 4'h0, 11'h000);
            chk(rdata, 4'(~v));
        end
        // Carry is 1 from the last adjust step; accumulator holds v + x of the last pass
        for (int b = 0; b < 9; b++)
        begin
            br <= (b < 8);
            brc <= ncd_br_t'(3'(b));
            prev = pc;
            j = 11'($urandom);
            seq.step(NCD_PC_JUMP, j, 3'h0);
            chk(pc, (b == 8 || br_exp(3'(b), 4'(v + x), 1'b1)) ? j : 11'(prev + 11'h001));
        end
        br <= 1'b0;
        d = 16'($urandom);
        rom_wr(pc, d);
        @(posedge mclk_in);
        #1;
        chk(instr, d);
        give_verdict();
    end
endmodule
`default_nettype wire
